/* rtl/rq_pkg.sv */
// shared constants of the radio byte queues and their serial link
package rq_pkg;
  localparam logic [6:0] ADDR_INT_STATUS = 7'h03;
  localparam logic [6:0] ADDR_INT_ENABLE = 7'h05;
  localparam logic [6:0] ADDR_MODE       = 7'h07;
  localparam logic [6:0] ADDR_CTRL2      = 7'h08;
  localparam logic [6:0] ADDR_TX_EXIT    = 7'h0B;
  localparam logic [6:0] ADDR_PKT_LEN    = 7'h3E;
  localparam logic [6:0] ADDR_TX_FULL    = 7'h7C;
  localparam logic [6:0] ADDR_TX_EMPTY   = 7'h7D;
  localparam logic [6:0] ADDR_RX_FULL    = 7'h7E;
  localparam logic [6:0] ADDR_QUEUE      = 7'h7F;
  localparam logic [6:0] QUEUE_DEPTH     = 7'h40;
  localparam logic [7:0] RST_MODE        = 8'h01;
  localparam logic [7:0] RST_CTRL2       = 8'h00;
  localparam logic [7:0] RST_PKT_LEN     = 8'h00;
  localparam logic [5:0] RST_TX_FULL     = 6'h37;
  localparam logic [5:0] RST_TX_EMPTY    = 6'h04;
  localparam logic [5:0] RST_RX_FULL     = 6'h37;
  localparam int         MODE_READY      = 0;
  localparam int         MODE_TXON       = 3;
  localparam int         CTRL2_FLUSH_TX  = 0;
  localparam int         CTRL2_FLUSH_RX  = 1;
  localparam int         ST_TX_FULL      = 0;
  localparam int         ST_TX_EMPTY     = 1;
  localparam int         ST_RX_FULL      = 2;
  localparam int         ST_PKT_SENT     = 3;
  localparam logic [2:0] H_START         = 3'h0;
  localparam logic [2:0] H_XFER          = 3'h1;
  localparam logic [2:0] H_STOP          = 3'h2;
  localparam logic [2:0] H_STATUS        = 3'h3;
  localparam logic [2:0] H_RDATA         = 3'h4;
  localparam logic [2:0] H_INT_STATUS    = 3'h5;
  localparam logic [2:0] H_INT_MASK      = 3'h6;
  localparam int         CLK_NS          = 4;
  localparam int         LINK_HALF_NS    = 64;
  localparam int         LINK_HALF_CYC   = LINK_HALF_NS / CLK_NS;
  localparam int         BYTE_CYC        = 64;
  typedef enum logic [2:0] {
    RQ_STANDBY = 3'h1,
    RQ_READY   = 3'h2,
    RQ_TX      = 3'h4
  } rq_state_t;
  typedef enum logic [2:0] {
    RQ_H_IDLE = 3'h1,
    RQ_H_LOW  = 3'h2,
    RQ_H_HIGH = 3'h4
  } rq_hstate_t;
endpackage

/* rtl/rq_link_if.sv */
// serial register link between host controller and radio queues
`timescale 1ns/1ns
interface rq_link_if;
  logic sck;
  logic mosi;
  logic nsel_low;
  logic miso;
  logic miso_oe;
  logic event_request_line_low;
  modport device (
    input  sck,
    input  mosi,
    input  nsel_low,
    output miso,
    output miso_oe,
    output event_request_line_low
  );
  modport host (
    output sck,
    output mosi,
    output nsel_low,
    input  miso,
    input  event_request_line_low
  );
endinterface

/* rtl/rq_device.sv */
// device end: serial slave, registers, byte queues, transmit engine
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module rq_device #(
  parameter int BYTE_CYCLES = rq_pkg::BYTE_CYC
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  rq_link_if.device         link,
  output logic [7:0]        modem_tx_data,
  output logic              modem_tx_strobe,
  input  wire logic [7:0]   modem_rx_data,
  input  wire logic         modem_rx_strobe,
  output rq_pkg::rq_state_t radio_state
);
  localparam int TW = $clog2(BYTE_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LOAD = TW'(BYTE_CYCLES - 1);

  function automatic logic lvl_up(logic [6:0] a, logic [6:0] b,
                                  logic [5:0] t);
    return (a < {1'b0, t}) && (b >= {1'b0, t});
  endfunction

  logic [2:0]    sck_s, mosi_s, nsel_s;
  logic          sck_f, mosi_f, nsel_f, sck_q;
  logic [2:0]    bit_cnt;
  logic [7:0]    shift_in, shift_out;
  logic          first_reg, rw_reg, miso_reg, miso_oe_reg;
  logic [6:0]    addr_reg;
  logic [7:0]    int_status_reg, int_en_reg, mode_reg, ctrl2_reg;
  logic [7:0]    exit_reg, pklen_reg, sent_reg;
  logic [5:0]    txf_thr_reg, txe_thr_reg, rxf_thr_reg;
  logic [7:0]    txq_mem [64];
  logic [7:0]    rxq_mem [64];
  logic [5:0]    txq_wr, txq_rd, rxq_wr, rxq_rd;
  logic [6:0]    txq_cnt, rxq_cnt;
  logic [TW-1:0] tick_cnt;
  logic          irq_n_reg;

  // link pins: a change counts once second and third stage agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_s  <= 3'h0;
      mosi_s <= 3'h0;
      nsel_s <= 3'h7;
      sck_f  <= 1'b0;
      mosi_f <= 1'b0;
      nsel_f <= 1'b1;
      sck_q  <= 1'b0;
    end else begin
      sck_s  <= {sck_s[1:0], link.sck};
      mosi_s <= {mosi_s[1:0], link.mosi};
      nsel_s <= {nsel_s[1:0], link.nsel_low};
      if (sck_s[1] == sck_s[2]) sck_f <= sck_s[2];
      if (mosi_s[1] == mosi_s[2]) mosi_f <= mosi_s[2];
      if (nsel_s[1] == nsel_s[2]) nsel_f <= nsel_s[2];
      sck_q <= sck_f;
    end
  end

  wire       sel       = ~nsel_f;
  wire       sck_rise  = sel & sck_f & ~sck_q;
  wire       sck_fall  = sel & ~sck_f & sck_q;
  wire       byte_done = sck_rise & (bit_cnt == 3'h7);
  wire [7:0] rx_byte   = {shift_in[6:0], mosi_f};
  wire       spi_wr    = byte_done & ~first_reg & rw_reg;
  wire       spi_rd    = byte_done & (first_reg ? ~rx_byte[7] : ~rw_reg);
  // the queue port holds its address across a burst
  wire [6:0] addr_inc  = (addr_reg == rq_pkg::ADDR_QUEUE) ? addr_reg
                         : addr_reg + 7'h01;
  wire [6:0] rd_addr   = first_reg ? rx_byte[6:0] : addr_inc;
  wire       wr_queue  = spi_wr & (addr_reg == rq_pkg::ADDR_QUEUE);
  wire       flush_tx  = ctrl2_reg[rq_pkg::CTRL2_FLUSH_TX];
  wire       flush_rx  = ctrl2_reg[rq_pkg::CTRL2_FLUSH_RX];

  // a queue byte leaves only once its byte has really been clocked out,
  // so ending a burst never loses the byte that was staged next
  wire       rxq_pop   = byte_done & ~first_reg & ~rw_reg & ~flush_rx &
                         (addr_reg == rq_pkg::ADDR_QUEUE) &
                         (rxq_cnt != 7'h00);
  wire [6:0] rxq_left  = rxq_cnt - {6'h00, rxq_pop};
  wire [7:0] rxq_peek  = (rxq_left == 7'h00 || flush_rx) ? 8'h00
                         : rxq_mem[rxq_rd + {5'h00, rxq_pop}];
  wire [7:0] rd_val    =
    (rd_addr == rq_pkg::ADDR_INT_STATUS) ? int_status_reg :
    (rd_addr == rq_pkg::ADDR_INT_ENABLE) ? int_en_reg :
    (rd_addr == rq_pkg::ADDR_MODE)       ? mode_reg :
    (rd_addr == rq_pkg::ADDR_CTRL2)      ? ctrl2_reg :
    (rd_addr == rq_pkg::ADDR_TX_EXIT)    ? exit_reg :
    (rd_addr == rq_pkg::ADDR_PKT_LEN)    ? pklen_reg :
    (rd_addr == rq_pkg::ADDR_TX_FULL)    ? {2'h0, txf_thr_reg} :
    (rd_addr == rq_pkg::ADDR_TX_EMPTY)   ? {2'h0, txe_thr_reg} :
    (rd_addr == rq_pkg::ADDR_RX_FULL)    ? {2'h0, rxf_thr_reg} :
    (rd_addr == rq_pkg::ADDR_QUEUE)      ? rxq_peek : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn || !sel) begin
      bit_cnt     <= 3'h0;
      shift_in    <= 8'h00;
      shift_out   <= 8'h00;
      first_reg   <= 1'b1;
      rw_reg      <= 1'b0;
      addr_reg    <= 7'h00;
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= 1'b1;
      if (sck_rise) begin
        bit_cnt  <= bit_cnt + 3'h1;
        shift_in <= rx_byte;
      end
      if (byte_done && first_reg) begin
        first_reg <= 1'b0;
        rw_reg    <= rx_byte[7];
        addr_reg  <= rx_byte[6:0];
      end else if (byte_done) begin
        addr_reg <= addr_inc;
      end
      if (spi_rd) begin
        shift_out <= rd_val;
      end else if (sck_fall) begin
        miso_reg  <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // transmit engine: one byte per tick while transmit is on
  wire       tx_on     = mode_reg[rq_pkg::MODE_TXON];
  wire       tick      = tx_on & (tick_cnt == '0);
  wire       txq_pop   = tick & (txq_cnt != 7'h00) & ~flush_tx;
  wire       txq_push  = wr_queue & ~flush_tx &
                         (txq_cnt != rq_pkg::QUEUE_DEPTH);
  wire       rxq_push  = modem_rx_strobe & ~flush_rx &
                         (rxq_cnt != rq_pkg::QUEUE_DEPTH);
  wire       pkt_end   = txq_pop & (pklen_reg != 8'h00) &
                         (sent_reg + 8'h01 == pklen_reg);
  wire       empty_end = tick & (txq_cnt == 7'h00) &
                         exit_reg[0];
  wire [6:0] txq_next  = flush_tx ? 7'h00
                         : txq_cnt + {6'h00, txq_push} - {6'h00, txq_pop};
  wire [6:0] rxq_next  = flush_rx ? 7'h00
                         : rxq_cnt + {6'h00, rxq_push} - {6'h00, rxq_pop};
  wire [3:0] events    = {
    pkt_end,
    ~flush_rx & lvl_up(rxq_cnt, rxq_next, rxf_thr_reg),
    ~flush_tx & lvl_up(txq_next, txq_cnt, txe_thr_reg),
    lvl_up(txq_cnt, txq_next, txf_thr_reg)
  };
  wire       w_status  = spi_wr & (addr_reg == rq_pkg::ADDR_INT_STATUS);
  wire [7:0] status_next = (int_status_reg & ~(w_status ? rx_byte : 8'h00))
                           | {4'h0, events};
  wire       w_mode    = spi_wr & (addr_reg == rq_pkg::ADDR_MODE);
  // a host mode write in the same cycle as a packet end wins
  wire [7:0] mode_next = w_mode ? rx_byte
                         : (pkt_end | empty_end)
                         ? (mode_reg & ~(8'h01 << rq_pkg::MODE_TXON))
                         : mode_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_status_reg <= 8'h00;
      int_en_reg     <= 8'h00;
      mode_reg       <= rq_pkg::RST_MODE;
      ctrl2_reg      <= rq_pkg::RST_CTRL2;
      exit_reg       <= 8'h00;
      pklen_reg      <= rq_pkg::RST_PKT_LEN;
      txf_thr_reg    <= rq_pkg::RST_TX_FULL;
      txe_thr_reg    <= rq_pkg::RST_TX_EMPTY;
      rxf_thr_reg    <= rq_pkg::RST_RX_FULL;
    end else begin
      int_status_reg <= status_next;
      mode_reg       <= mode_next;
      if (spi_wr) begin
        case (addr_reg)
          rq_pkg::ADDR_INT_ENABLE: int_en_reg  <= rx_byte;
          rq_pkg::ADDR_CTRL2:      ctrl2_reg   <= rx_byte;
          rq_pkg::ADDR_TX_EXIT:    exit_reg    <= {7'h00, rx_byte[0]};
          rq_pkg::ADDR_PKT_LEN:    pklen_reg   <= rx_byte;
          rq_pkg::ADDR_TX_FULL:    txf_thr_reg <= rx_byte[5:0];
          rq_pkg::ADDR_TX_EMPTY:   txe_thr_reg <= rx_byte[5:0];
          rq_pkg::ADDR_RX_FULL:    rxf_thr_reg <= rx_byte[5:0];
          default: ;
        endcase
      end
    end
  end

  // queues: flush holds pointers and counts at zero while set
  always_ff @(posedge clk) begin
    if (!rstn || flush_tx) begin
      txq_wr  <= 6'h00;
      txq_rd  <= 6'h00;
      txq_cnt <= 7'h00;
    end else begin
      txq_cnt <= txq_next;
      if (txq_push) txq_wr <= txq_wr + 6'h01;
      if (txq_pop) txq_rd <= txq_rd + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || flush_rx) begin
      rxq_wr  <= 6'h00;
      rxq_rd  <= 6'h00;
      rxq_cnt <= 7'h00;
    end else begin
      rxq_cnt <= rxq_next;
      if (rxq_push) rxq_wr <= rxq_wr + 6'h01;
      if (rxq_pop) rxq_rd <= rxq_rd + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (txq_push) txq_mem[txq_wr] <= rx_byte;
    if (rxq_push) rxq_mem[rxq_wr] <= modem_rx_data;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_cnt        <= TICK_LOAD;
      sent_reg        <= 8'h00;
      modem_tx_data   <= 8'h00;
      modem_tx_strobe <= 1'b0;
      radio_state     <= rq_pkg::RQ_READY;
      irq_n_reg       <= 1'b1;
    end else begin
      tick_cnt        <= (!tx_on || tick) ? TICK_LOAD : tick_cnt - 1'b1;
      modem_tx_strobe <= txq_pop;
      if (txq_pop) modem_tx_data <= txq_mem[txq_rd];
      if (!tx_on || pkt_end) sent_reg <= 8'h00;
      else if (txq_pop) sent_reg <= sent_reg + 8'h01;
      if (mode_next[rq_pkg::MODE_TXON]) radio_state <= rq_pkg::RQ_TX;
      else if (mode_next[rq_pkg::MODE_READY]) radio_state <= rq_pkg::RQ_READY;
      else radio_state <= rq_pkg::RQ_STANDBY;
      irq_n_reg <= ~|(status_next & int_en_reg);
    end
  end

  assign link.miso                   = miso_reg;
  assign link.miso_oe                = miso_oe_reg;
  assign link.event_request_line_low = irq_n_reg;
endmodule

/* rtl/rq_host.sv */
// host end: register-driven serial master of the radio queue link
`timescale 1ns/1ns
module rq_host #(
  parameter int HALF_CYCLES = rq_pkg::LINK_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  rq_link_if.host         link,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq
);
  localparam int HW = $clog2(HALF_CYCLES + 1);
  localparam logic [HW-1:0] HALF_END = HW'(HALF_CYCLES - 1);

  rq_pkg::rq_hstate_t state;
  logic [HW-1:0] div_cnt;
  logic [2:0]    bit_cnt;
  logic [7:0]    tx_sh, rx_sh, rdata_reg, int_st_reg, mask_reg;
  logic          sck_reg, mosi_reg, nsel_reg, done_ev;
  logic [2:0]    miso_s, irq_s;
  logic          miso_f, irq_f, irq_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      miso_s <= 3'h0;
      irq_s  <= 3'h7;
      miso_f <= 1'b0;
      irq_f  <= 1'b1;
      irq_q  <= 1'b1;
    end else begin
      miso_s <= {miso_s[1:0], link.miso};
      irq_s  <= {irq_s[1:0], link.event_request_line_low};
      if (miso_s[1] == miso_s[2]) miso_f <= miso_s[2];
      if (irq_s[1] == irq_s[2]) irq_f <= irq_s[2];
      irq_q <= irq_f;
    end
  end

  wire idle     = (state == rq_pkg::RQ_H_IDLE);
  wire half_end = (div_cnt == HALF_END);
  // commands arriving while a byte is moving are dropped
  wire go_start = reg_wr & idle & (reg_addr == rq_pkg::H_START);
  wire go_xfer  = reg_wr & idle & ~nsel_reg & (reg_addr == rq_pkg::H_XFER);
  wire go_stop  = reg_wr & idle & (reg_addr == rq_pkg::H_STOP);
  wire w_int    = reg_wr & (reg_addr == rq_pkg::H_INT_STATUS);
  wire irq_ev   = irq_q & ~irq_f;
  wire [7:0] st_next = (int_st_reg & ~(w_int ? reg_wdata : 8'h00))
                       | {6'h00, irq_ev, done_ev};
  wire [7:0] rd_val  =
    (reg_addr == rq_pkg::H_STATUS)     ? {5'h00, ~irq_f, ~nsel_reg, ~idle} :
    (reg_addr == rq_pkg::H_RDATA)      ? rdata_reg :
    (reg_addr == rq_pkg::H_INT_STATUS) ? int_st_reg :
    (reg_addr == rq_pkg::H_INT_MASK)   ? mask_reg : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state    <= rq_pkg::RQ_H_IDLE;
      div_cnt  <= '0;
      bit_cnt  <= 3'h0;
      tx_sh    <= 8'h00;
      rx_sh    <= 8'h00;
      sck_reg  <= 1'b0;
      mosi_reg <= 1'b0;
      nsel_reg <= 1'b1;
      done_ev  <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      div_cnt <= (idle || half_end) ? '0 : div_cnt + 1'b1;
      case (state)
        rq_pkg::RQ_H_IDLE: begin
          if (go_start || go_xfer) begin
            nsel_reg <= 1'b0;
            tx_sh    <= reg_wdata;
            mosi_reg <= reg_wdata[7];
            bit_cnt  <= 3'h0;
            state    <= rq_pkg::RQ_H_LOW;
          end else if (go_stop) begin
            nsel_reg <= 1'b1;
          end
        end
        rq_pkg::RQ_H_LOW: begin
          if (half_end) begin
            sck_reg <= 1'b1;
            rx_sh   <= {rx_sh[6:0], miso_f};
            state   <= rq_pkg::RQ_H_HIGH;
          end
        end
        rq_pkg::RQ_H_HIGH: begin
          if (half_end) begin
            sck_reg <= 1'b0;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              done_ev <= 1'b1;
              state   <= rq_pkg::RQ_H_IDLE;
            end else begin
              tx_sh    <= {tx_sh[6:0], 1'b0};
              mosi_reg <= tx_sh[6];
              state    <= rq_pkg::RQ_H_LOW;
            end
          end
        end
        default: state <= rq_pkg::RQ_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_reg  <= 8'h00;
      int_st_reg <= 8'h00;
      mask_reg   <= 8'h00;
      reg_rdata  <= 8'h00;
      irq        <= 1'b0;
    end else begin
      if (done_ev) rdata_reg <= rx_sh;
      if (reg_wr && reg_addr == rq_pkg::H_INT_MASK) mask_reg <= reg_wdata;
      int_st_reg <= st_next;
      reg_rdata  <= reg_rd ? rd_val : 8'h00;
      irq        <= |(st_next & mask_reg);
    end
  end

  assign link.sck      = sck_reg;
  assign link.mosi     = mosi_reg;
  assign link.nsel_low = nsel_reg;
endmodule

/* sim/rq_properties.sv */
// link-level timing properties of the radio queue serial link
`timescale 1ns/1ns
module rq_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic nsel_low,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic event_request_line_low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_sck_idle;
    nsel_low && $past(nsel_low) |-> !sck;
  endproperty
  property p_oe_off;
    nsel_low [*8] |-> !miso_oe;
  endproperty
  property p_oe_on;
    !nsel_low [*8] |-> miso_oe;
  endproperty
  // mode 0: the device samples mosi on the rise, so it must hold while high
  property p_mosi_hold;
    sck && $past(sck) |-> $stable(mosi);
  endproperty
  // miso moves a few cycles after the fall, never late in the high phase
  property p_miso_hold;
    sck [*6] |-> $stable(miso);
  endproperty
  property p_sck_high;
    $rose(sck) |-> sck [*8];
  endproperty
  property p_sck_low;
    $fell(sck) |-> !sck [*8];
  endproperty
  property p_first_edge;
    $fell(nsel_low) |-> !sck [*8];
  endproperty

  a_sck_idle:    assert property (p_sck_idle)
    else $error("link clock moved while deselected");
  a_oe_off:      assert property (p_oe_off)
    else $error("miso driven while deselected");
  a_oe_on:       assert property (p_oe_on)
    else $error("miso not driven while selected");
  a_mosi_hold:   assert property (p_mosi_hold)
    else $error("mosi changed while link clock high");
  a_miso_hold:   assert property (p_miso_hold)
    else $error("miso changed late in link clock high phase");
  a_sck_high:    assert property (p_sck_high)
    else $error("link clock high phase too short");
  a_sck_low:     assert property (p_sck_low)
    else $error("link clock low phase too short");
  a_first_edge:  assert property (p_first_edge)
    else $error("link clock rose too soon after select");

  c_select:  cover property ($fell(nsel_low));
  c_event:   cover property ($fell(event_request_line_low));
  c_drive:   cover property ($rose(miso_oe));
endmodule

/* sim/test_radio_tx_rx_byte_queues.sv */
// register-level testbench of both radio queue link ends
`timescale 1ns/1ns
module test_radio_tx_rx_byte_queues;
  logic              clk       = 1'b0;
  logic              rstn      = 1'b0;
  logic [2:0]        reg_addr  = 3'h0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [7:0]        reg_rdata;
  logic              irq;
  logic [7:0]        rx_data   = 8'h00;
  logic              rx_stb    = 1'b0;
  logic [7:0]        tx_data;
  logic              tx_stb;
  rq_pkg::rq_state_t state;
  logic [7:0]        txq[$];
  logic [7:0]        d;
  int                bad_count = 0;
  int                tests_run = 0;
  logic [6:0]        ra[8] = '{7'h07, 7'h08, 7'h3E, 7'h7C, 7'h7D, 7'h7E,
                               7'h05, 7'h03};
  logic [7:0]        rv[8] = '{8'h01, 8'h00, 8'h00, 8'h37, 8'h04, 8'h37,
                               8'h00, 8'h00};

  rq_link_if link();

  // short byte period keeps the transmit scenarios brief
  rq_device #(.BYTE_CYCLES(4)) i_rq_device (
    .clk             (clk),
    .rstn            (rstn),
    .link            (link),
    .modem_tx_data   (tx_data),
    .modem_tx_strobe (tx_stb),
    .modem_rx_data   (rx_data),
    .modem_rx_strobe (rx_stb),
    .radio_state     (state)
  );
  rq_host i_rq_host (
    .clk       (clk),
    .rstn      (rstn),
    .link      (link),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq)
  );
  rq_properties i_rq_properties (
    .clk                    (clk),
    .rstn                   (rstn),
    .sck                    (link.sck),
    .mosi                   (link.mosi),
    .nsel_low               (link.nsel_low),
    .miso                   (link.miso),
    .miso_oe                (link.miso_oe),
    .event_request_line_low (link.event_request_line_low)
  );

  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (tx_stb === 1'b1) txq.push_back(tx_data);
  end

  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // a byte takes 256 cycles, so 300 status polls is ample
  task automatic idle;
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(rq_pkg::H_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    bad_count++;
    finish_test;
  endtask

  task automatic start(input logic [7:0] h);
    wr(rq_pkg::H_START, h);
    idle;
  endtask

  task automatic xfer(input logic [7:0] v);
    wr(rq_pkg::H_XFER, v);
    idle;
  endtask

  // the device sees deselect only after its input synchroniser
  task automatic stop;
    wr(rq_pkg::H_STOP, 8'h00);
    repeat (8) @(posedge clk);
  endtask

  task automatic sw(input logic [6:0] a, input logic [7:0] v);
    start({1'b1, a});
    xfer(v);
    stop;
  endtask

  task automatic sr(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    start({1'b0, a});
    xfer(8'h00);
    rd(rq_pkg::H_RDATA, v);
    stop;
    chk(v, exp);
  endtask

  task automatic push(input logic [7:0] v);
    @(posedge clk);
    rx_data <= v;
    rx_stb  <= 1'b1;
    @(posedge clk);
    rx_stb  <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) sr(ra[i], rv[i]);
    sw(7'h05, 8'h0F);
    sw(7'h3E, 8'h04);
    sw(7'h7C, 8'h03);
    sw(7'h7D, 8'h02);
    sw(7'h0B, 8'h01);
    wr(rq_pkg::H_INT_MASK, 8'h02);
    start(8'hFF);
    for (int i = 0; i < 5; i++) xfer(8'hA0 + i[7:0]);
    stop;
    sr(7'h03, 8'h01);
    chk({7'h0, link.event_request_line_low}, 8'h00);
    chk({7'h0, irq}, 8'h01);
    rd(rq_pkg::H_STATUS, d);
    chk(d, 8'h04);
    rd(rq_pkg::H_INT_STATUS, d);
    chk(d, 8'h03);
    rd(rq_pkg::H_INT_MASK, d);
    chk(d, 8'h02);
    sw(7'h03, 8'h01);
    wr(rq_pkg::H_INT_STATUS, 8'h02);
    sw(7'h07, 8'h09);
    repeat (100) @(posedge clk);
    chk(8'(txq.size()), 8'h04);
    for (int i = 0; i < 4; i++) chk(txq.pop_front(), 8'hA0 + i[7:0]);
    chk({5'h0, state}, {5'h0, rq_pkg::RQ_READY});
    sr(7'h03, 8'h0A);
    sw(7'h03, 8'h0A);
    wr(rq_pkg::H_INT_STATUS, 8'h02);
    sw(7'h07, 8'h08);
    repeat (100) @(posedge clk);
    chk(txq.pop_front(), 8'hA4);
    chk({5'h0, state}, {5'h0, rq_pkg::RQ_STANDBY});
    sr(7'h03, 8'h00);
    sw(7'h05, 8'h0B);
    sw(7'h7E, 8'h03);
    for (int i = 0; i < 66; i++) push(8'h10 + i[7:0]);
    sr(7'h03, 8'h04);
    chk({7'h0, link.event_request_line_low}, 8'h01);
    chk({7'h0, irq}, 8'h00);
    start(8'h7F);
    for (int i = 0; i < 65; i++) begin
      xfer(8'h00);
      rd(rq_pkg::H_RDATA, d);
      chk(d, (i < 64) ? 8'h10 + i[7:0] : 8'h00);
    end
    stop;
    push(8'h55);
    sw(7'h08, 8'h02);
    sw(7'h08, 8'h00);
    sr(7'h7F, 8'h00);
    start(8'hFF);
    xfer(8'h66);
    stop;
    sw(7'h08, 8'h01);
    sw(7'h08, 8'h00);
    sw(7'h07, 8'h09);
    repeat (100) @(posedge clk);
    chk(8'(txq.size()), 8'h00);
    finish_test;
  end
endmodule
